// >>> src/smiod_decoder.sv
/*
  Decoder and timing unit for extending moves, pushes, pops, operand swap and
  port input/output. Assumes the prefetch queue presents up to three opcode
  bytes at once and holds them while instValid is high and instReady is low.
*/
// Overview of operation
// RQ1: 0F then 1011111w is sign-extending move; 3 clocks register, 6 memory.
// RQ2: 0F then 1011011w is zero-extending move; 3 clocks register, 6 memory.
// RQ3: 0F then 10sss000 pushes segment sss; 2 clocks real, 4 protected.
// RQ4: 011010s0 pushes immediate, s selects sign-extended short; 2 real, 4 protected.
// RQ5: 8F with reg zero pops; 5/7 real, 7/9 protected, register/memory.
// RQ6: 000ss111 pops legacy segment; 7 clocks real, 25 protected.
// RQ7: 1000011w swaps operands; 3 clocks register, 5 memory with read and write.
// RQ8: Port input 12 fixed, 13 variable real; protected 6/26 and 7/27.
// RQ9: Port output 10 fixed, 11 variable real; protected 4/24 and 5/25.
// RQ10: Width bit zero selects byte, one full size; byte/word source for extends.
`timescale 1ns/1ps
`default_nettype none
module smiod_decoder (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instValid,
  input wire logic [7:0] opByte0,
  input wire logic [7:0] opByte1,
  input wire logic [7:0] opByte2,
  input wire logic protMode,
  input wire logic ioSlowPath,
  output logic instReady,
  output smiod_pkg::smiod_op_t opClass,
  output logic wideOp,
  output logic signExtImm,
  output logic [2:0] segSel,
  output logic memOperand,
  output logic memReadWrite,
  output logic [smiod_pkg::CNT_W-1:0] cycleCount,
  output logic unknownOp,
  output logic execBusy,
  output logic execDone
);
  import smiod_pkg::*;

  typedef struct packed {
    smiod_op_t op;
    logic wide;
    logic sext;
    logic [2:0] seg;
    logic mem;
    logic rmw;
    logic [CNT_W-1:0] count;
    logic unknown;
  } smiod_dec_t;

  smiod_dec_t st_q;
  smiod_dec_t st_d;
  logic accept;
  logic timerBusy;
  logic timerLast;

  // A mod field of 11 names a register; any other names memory.
  function automatic logic isMemory(input logic [7:0] modrm);
    return modrm[MOD_LSB +: 2] != MOD_REGISTER;
  endfunction : isMemory

  function automatic logic [CNT_W-1:0] pickCount(input logic sel,
      input logic [CNT_W-1:0] whenLow, input logic [CNT_W-1:0] whenHigh);
    return sel ? whenHigh : whenLow;
  endfunction : pickCount

  assign instReady = !timerBusy;
  assign accept = instValid && instReady;

  always_comb begin
    st_d = st_q;
    st_d.unknown = 1'b0;
    if (accept) begin
      st_d.op = OP_NONE;
      st_d.wide = opByte0[WIDTH_BIT]; // RQ10
      st_d.sext = 1'b0;
      st_d.seg = 3'h0;
      st_d.mem = 1'b0;
      st_d.rmw = 1'b0;
      st_d.count = '0;
      if (opByte0 == OPC_ESCAPE) begin
        st_d.wide = opByte1[WIDTH_BIT]; // RQ10
        if (opByte1[7:1] == OPC_SEXT_HI) begin
          st_d.op = OP_SIGN_EXTEND_MOVE;
          st_d.mem = isMemory(opByte2);
          st_d.count = pickCount(isMemory(opByte2), CNT_EXT_REG, CNT_EXT_MEM); // RQ1
        end else if (opByte1[7:1] == OPC_ZEXT_HI) begin
          st_d.op = OP_ZERO_EXTEND_MOVE;
          st_d.mem = isMemory(opByte2);
          st_d.count = pickCount(isMemory(opByte2), CNT_EXT_REG, CNT_EXT_MEM); // RQ2
        end else if (opByte1[7:6] == OPC_SEGPUSH_TOP && opByte1[2:0] == OPC_SEGPUSH_LOW) begin
          st_d.op = OP_PUSH_SEGMENT;
          st_d.seg = opByte1[5:3];
          st_d.count = pickCount(protMode, CNT_PUSH_REAL, CNT_PUSH_PROT); // RQ3
        end else if (opByte1[7:6] == OPC_SEGPUSH_TOP && opByte1[2:0] == OPC_SEGPOP2_LOW) begin
          st_d.op = OP_POP_SEGMENT;
          st_d.seg = opByte1[5:3];
          st_d.count = pickCount(protMode, CNT_SEGPOP_REAL, CNT_SEGPOP_PROT);
        end
      end else if (opByte0[7:2] == OPC_PUSHIMM_HI && !opByte0[WIDTH_BIT]) begin
        st_d.op = OP_PUSH_IMMEDIATE;
        st_d.wide = 1'b1;
        st_d.sext = opByte0[SIGN_BIT];
        st_d.count = pickCount(protMode, CNT_PUSH_REAL, CNT_PUSH_PROT); // RQ4
      end else if (opByte0 == OPC_POP_RM && opByte1[REG_LSB +: 3] == REG_FIELD_ZERO) begin
        st_d.op = OP_POP_RM;
        st_d.wide = 1'b1;
        st_d.mem = isMemory(opByte1);
        if (protMode) begin
          st_d.count = pickCount(isMemory(opByte1), CNT_POPRM_PROT_REG, CNT_POPRM_PROT_MEM); // RQ5
        end else begin
          st_d.count = pickCount(isMemory(opByte1), CNT_POPRM_REAL_REG, CNT_POPRM_REAL_MEM); // RQ5
        end
      end else if (opByte0[7:5] == OPC_SEGPOP_TOP && opByte0[2:0] == OPC_SEGPOP_LOW) begin
        // The escape byte shares this pattern, so it is tested first above.
        st_d.op = OP_POP_SEGMENT;
        st_d.wide = 1'b1;
        st_d.seg = {1'b0, opByte0[4:3]};
        st_d.count = pickCount(protMode, CNT_SEGPOP_REAL, CNT_SEGPOP_PROT); // RQ6
      end else if (opByte0[7:1] == OPC_SWAP_HI) begin
        st_d.op = OP_SWAP_OPERANDS;
        st_d.mem = isMemory(opByte1);
        st_d.rmw = isMemory(opByte1); // RQ7
        st_d.count = pickCount(isMemory(opByte1), CNT_SWAP_REG, CNT_SWAP_MEM); // RQ7
      end else if (opByte0[7:1] == OPC_IN_FIX_HI || opByte0[7:1] == OPC_IN_VAR_HI) begin
        st_d.op = OP_PORT_IN;
        if (opByte0[7:1] == OPC_IN_FIX_HI) begin
          st_d.count = protMode ? pickCount(ioSlowPath, CNT_IN_FIX_FAST, CNT_IN_FIX_SLOW)
                                : CNT_IN_FIX_REAL; // RQ8
        end else begin
          st_d.count = protMode ? pickCount(ioSlowPath, CNT_IN_VAR_FAST, CNT_IN_VAR_SLOW)
                                : CNT_IN_VAR_REAL; // RQ8
        end
      end else if (opByte0[7:1] == OPC_OUT_FIX_HI || opByte0[7:1] == OPC_OUT_VAR_HI) begin
        st_d.op = OP_PORT_OUT;
        if (opByte0[7:1] == OPC_OUT_FIX_HI) begin
          st_d.count = protMode ? pickCount(ioSlowPath, CNT_OUT_FIX_FAST, CNT_OUT_FIX_SLOW)
                                : CNT_OUT_FIX_REAL; // RQ9
        end else begin
          st_d.count = protMode ? pickCount(ioSlowPath, CNT_OUT_VAR_FAST, CNT_OUT_VAR_SLOW)
                                : CNT_OUT_VAR_REAL; // RQ9
        end
      end
      st_d.unknown = (st_d.op == OP_NONE);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Unknown opcodes never start the timer, so other groups pass straight on.
  smiod_exec_timer u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(accept && st_d.op != OP_NONE),
    .loadCount(st_d.count),
    .busy(timerBusy),
    .lastCycle(timerLast)
  );

  assign opClass = st_q.op;
  assign wideOp = st_q.wide;
  assign signExtImm = st_q.sext;
  assign segSel = st_q.seg;
  assign memOperand = st_q.mem;
  assign memReadWrite = st_q.rmw;
  assign cycleCount = st_q.count;
  assign unknownOp = st_q.unknown;
  assign execBusy = timerBusy;
  assign execDone = timerLast;

  chk_sext_move_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && opByte0 == 8'h0F && opByte1[7:1] == 7'h5F
    |=> opClass == OP_SIGN_EXTEND_MOVE && cycleCount == (memOperand ? 5'h06 : 5'h03)
    && memOperand == ($past(opByte2[7:6]) != 2'h3)) // RQ1
    else $error("sign-extending move count wrong");

  chk_zext_move_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && opByte0 == 8'h0F && opByte1[7:1] == 7'h5B && opByte2[7:6] == 2'h3
    |=> opClass == OP_ZERO_EXTEND_MOVE ##0 execBusy[*3] ##1 !execBusy) // RQ2
    else $error("zero-extending move register timing wrong");

  chk_seg_push_sel: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && opByte0 == 8'h0F && opByte1[7:6] == 2'h2 && opByte1[2:0] == 3'h0
    |=> segSel == $past(opByte1[5:3]) && cycleCount == ($past(protMode) ? 5'h04 : 5'h02)) // RQ3
    else $error("segment push decode wrong");

  chk_imm_push_sext: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && opByte0[7:2] == 6'h1A && !opByte0[0]
    |=> opClass == OP_PUSH_IMMEDIATE && signExtImm == $past(opByte0[1])) // RQ4
    else $error("immediate push sign select wrong");

  chk_pop_rm_prot: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && protMode && opByte0 == 8'h8F && opByte1[5:3] == 3'h0
    |=> cycleCount == (memOperand ? 5'h09 : 5'h07)
    && memOperand == ($past(opByte1[7:6]) != 2'h3)) // RQ5
    else $error("protected pop count wrong");

  chk_seg_pop_prot: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && protMode && opByte0[7:5] == 3'h0 && opByte0[2:0] == 3'h7 && opByte0 != 8'h0F
    |=> opClass == OP_POP_SEGMENT && cycleCount == 5'h19 && segSel[2] == 1'b0) // RQ6
    else $error("legacy segment pop decode wrong");

  chk_swap_mem_rmw: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && opByte0[7:1] == 7'h43 && opByte1[7:6] != 2'h3
    |=> memReadWrite && cycleCount == 5'h05) // RQ7
    else $error("memory swap not marked read-write");

  chk_port_in_slow: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && protMode && ioSlowPath && opByte0[7:1] == 7'h76
    |=> opClass == OP_PORT_IN && cycleCount == 5'h1B) // RQ8
    else $error("variable port input slow count wrong");

  chk_port_out_real: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && !protMode && opByte0[7:1] == 7'h73
    |=> opClass == OP_PORT_OUT && cycleCount == 5'h0A) // RQ9
    else $error("fixed port output real count wrong");

  chk_width_bit_swap: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && opByte0[7:1] == 7'h43 |=> wideOp == $past(opByte0[0])) // RQ10
    else $error("width bit not carried");

endmodule : smiod_decoder
`default_nettype wire

// >>> src/smiod_exec_timer.sv
/*
  Execution timer: holds busy for the loaded number of clocks and flags the
  last one. Assumes start is only raised while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module smiod_exec_timer (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic [smiod_pkg::CNT_W-1:0] loadCount,
  output logic busy,
  output logic lastCycle
);
  import smiod_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] remain;
  } smiod_tmr_t;

  smiod_tmr_t st_q;
  smiod_tmr_t st_d;

  always_comb begin
    st_d = st_q;
    if (start) begin
      st_d.remain = loadCount;
    end else if (st_q.remain != '0) begin
      st_d.remain = st_q.remain - 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = (st_q.remain != '0);
  assign lastCycle = (st_q.remain == 5'h01);

  chk_timer_span_exact: assert property (@(posedge clk_sys) disable iff (!nrst)
    start && loadCount == 5'h03 |=> busy[*3] ##0 lastCycle ##1 !busy) // RQ1
    else $error("timer span differs from loaded count");

endmodule : smiod_exec_timer
`default_nettype wire

// >>> src/smiod_pkg.sv
/*
  Shared constants and types of the opcode decoder for the stack, move and
  port groups. Assumes the clock counts are those of zero-wait-state buses.
*/
package smiod_pkg;

  localparam int CNT_W = 5;

  // Opcode bytes and masks.
  localparam logic [7:0] OPC_ESCAPE = 8'h0F;
  localparam logic [6:0] OPC_SEXT_HI = 7'h5F;
  localparam logic [6:0] OPC_ZEXT_HI = 7'h5B;
  localparam logic [1:0] OPC_SEGPUSH_TOP = 2'h2;
  localparam logic [2:0] OPC_SEGPUSH_LOW = 3'h0;
  localparam logic [2:0] OPC_SEGPOP2_LOW = 3'h1;
  localparam logic [5:0] OPC_PUSHIMM_HI = 6'h1A;
  localparam logic [7:0] OPC_POP_RM = 8'h8F;
  localparam logic [2:0] OPC_SEGPOP_TOP = 3'h0;
  localparam logic [2:0] OPC_SEGPOP_LOW = 3'h7;
  localparam logic [6:0] OPC_SWAP_HI = 7'h43;
  localparam logic [6:0] OPC_IN_FIX_HI = 7'h72;
  localparam logic [6:0] OPC_IN_VAR_HI = 7'h76;
  localparam logic [6:0] OPC_OUT_FIX_HI = 7'h73;
  localparam logic [6:0] OPC_OUT_VAR_HI = 7'h77;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam logic [2:0] REG_FIELD_ZERO = 3'h0;

  // Field positions.
  localparam int WIDTH_BIT = 0;
  localparam int SIGN_BIT = 1;
  localparam int MOD_LSB = 6;
  localparam int REG_LSB = 3;

  // Clock counts.
  localparam logic [CNT_W-1:0] CNT_EXT_REG = 5'h03;
  localparam logic [CNT_W-1:0] CNT_EXT_MEM = 5'h06;
  localparam logic [CNT_W-1:0] CNT_PUSH_REAL = 5'h02;
  localparam logic [CNT_W-1:0] CNT_PUSH_PROT = 5'h04;
  localparam logic [CNT_W-1:0] CNT_POPRM_REAL_REG = 5'h05;
  localparam logic [CNT_W-1:0] CNT_POPRM_REAL_MEM = 5'h07;
  localparam logic [CNT_W-1:0] CNT_POPRM_PROT_REG = 5'h07;
  localparam logic [CNT_W-1:0] CNT_POPRM_PROT_MEM = 5'h09;
  localparam logic [CNT_W-1:0] CNT_SEGPOP_REAL = 5'h07;
  localparam logic [CNT_W-1:0] CNT_SEGPOP_PROT = 5'h19;
  localparam logic [CNT_W-1:0] CNT_SWAP_REG = 5'h03;
  localparam logic [CNT_W-1:0] CNT_SWAP_MEM = 5'h05;
  localparam logic [CNT_W-1:0] CNT_IN_FIX_REAL = 5'h0C;
  localparam logic [CNT_W-1:0] CNT_IN_FIX_FAST = 5'h06;
  localparam logic [CNT_W-1:0] CNT_IN_FIX_SLOW = 5'h1A;
  localparam logic [CNT_W-1:0] CNT_IN_VAR_REAL = 5'h0D;
  localparam logic [CNT_W-1:0] CNT_IN_VAR_FAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_IN_VAR_SLOW = 5'h1B;
  localparam logic [CNT_W-1:0] CNT_OUT_FIX_REAL = 5'h0A;
  localparam logic [CNT_W-1:0] CNT_OUT_FIX_FAST = 5'h04;
  localparam logic [CNT_W-1:0] CNT_OUT_FIX_SLOW = 5'h18;
  localparam logic [CNT_W-1:0] CNT_OUT_VAR_REAL = 5'h0B;
  localparam logic [CNT_W-1:0] CNT_OUT_VAR_FAST = 5'h05;
  localparam logic [CNT_W-1:0] CNT_OUT_VAR_SLOW = 5'h19;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_SIGN_EXTEND_MOVE,
    OP_ZERO_EXTEND_MOVE,
    OP_PUSH_SEGMENT,
    OP_PUSH_IMMEDIATE,
    OP_POP_RM,
    OP_POP_SEGMENT,
    OP_SWAP_OPERANDS,
    OP_PORT_IN,
    OP_PORT_OUT
  } smiod_op_t;

endpackage : smiod_pkg

// >>> test/smiod_queue_model.sv
/*
  Prefetch queue stand-in: presents one instruction's opcode bytes and holds
  them until the decoder takes them. Assumes the bench pulses load for one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module smiod_queue_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic load,
  input wire logic [7:0] ld0,
  input wire logic [7:0] ld1,
  input wire logic [7:0] ld2,
  input wire logic instReady,
  output logic instValid,
  output logic [7:0] opByte0,
  output logic [7:0] opByte1,
  output logic [7:0] opByte2,
  output logic taken
);
  // Taken bytes are inverted, so a decoder that samples outside a request sees junk.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      instValid <= 1'h0;
      taken <= 1'h0;
      opByte0 <= 8'h00;
      opByte1 <= 8'h00;
      opByte2 <= 8'h00;
    end else begin
      taken <= instValid && instReady;
      if (instValid && instReady) begin
        instValid <= 1'h0;
        opByte0 <= ~opByte0;
        opByte1 <= ~opByte1;
        opByte2 <= ~opByte2;
      end
      if (load) begin
        instValid <= 1'h1;
        opByte0 <= ld0;
        opByte1 <= ld1;
        opByte2 <= ld2;
      end
    end
  end
endmodule : smiod_queue_model
`default_nettype wire

// >>> test/stack_move_io_opcode_decode_bench.sv
/*
  Self-checking bench of the decoder: reset values, a table of opcodes, then
  back-to-back and mid-run reset cases. Assumes the queue model in front.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module stack_move_io_opcode_decode_bench;
  import smiod_pkg::*;
  // Mode nibble: protMode, ioSlowPath, wide, sign. Flag nibble: check mem, mem, swap mem, unknown.
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [3:0] m;
    smiod_op_t op;
    logic [2:0] seg;
    logic [3:0] f;
    logic [4:0] cnt;
  } smiod_row_t;
  logic clk_sys, nrst, load, protMode, ioSlowPath, taken, instValid, instReady;
  logic [7:0] ld0, ld1, ld2, opByte0, opByte1, opByte2;
  logic wideOp, signExtImm, memOperand, memReadWrite, unknownOp, execBusy, execDone;
  logic [2:0] segSel;
  logic [CNT_W-1:0] cycleCount;
  smiod_op_t opClass;
  logic [5:0] n;
  int fails, checks;
  smiod_row_t rows [30] = '{
    '{8'h0F, 8'hBF, 8'hC0, 4'h2, OP_SIGN_EXTEND_MOVE, 3'h0, 4'h8, 5'h03},
    '{8'h0F, 8'hBE, 8'h00, 4'h0, OP_SIGN_EXTEND_MOVE, 3'h0, 4'hC, 5'h06},
    '{8'h0F, 8'hB7, 8'h40, 4'hA, OP_ZERO_EXTEND_MOVE, 3'h0, 4'hC, 5'h06},
    '{8'h0F, 8'hB6, 8'hC1, 4'h8, OP_ZERO_EXTEND_MOVE, 3'h0, 4'h8, 5'h03},
    '{8'h0F, 8'hA8, 8'h00, 4'h0, OP_PUSH_SEGMENT, 3'h5, 4'h0, 5'h02},
    '{8'h0F, 8'hA0, 8'h00, 4'h8, OP_PUSH_SEGMENT, 3'h4, 4'h0, 5'h04},
    '{8'h6A, 8'h00, 8'h00, 4'h3, OP_PUSH_IMMEDIATE, 3'h0, 4'h0, 5'h02},
    '{8'h68, 8'h00, 8'h00, 4'hA, OP_PUSH_IMMEDIATE, 3'h0, 4'h0, 5'h04},
    '{8'h8F, 8'hC0, 8'h00, 4'h2, OP_POP_RM, 3'h0, 4'h8, 5'h05},
    '{8'h8F, 8'h00, 8'h00, 4'h2, OP_POP_RM, 3'h0, 4'hC, 5'h07},
    '{8'h8F, 8'hC3, 8'h00, 4'hA, OP_POP_RM, 3'h0, 4'h8, 5'h07},
    '{8'h8F, 8'h80, 8'h00, 4'hA, OP_POP_RM, 3'h0, 4'hC, 5'h09},
    '{8'h1F, 8'h00, 8'h00, 4'h2, OP_POP_SEGMENT, 3'h3, 4'h0, 5'h07},
    '{8'h07, 8'h00, 8'h00, 4'hA, OP_POP_SEGMENT, 3'h0, 4'h0, 5'h19},
    '{8'h0F, 8'hA9, 8'h00, 4'hA, OP_POP_SEGMENT, 3'h5, 4'h0, 5'h19},
    '{8'h87, 8'hC0, 8'h00, 4'h2, OP_SWAP_OPERANDS, 3'h0, 4'h8, 5'h03},
    '{8'h86, 8'h00, 8'h00, 4'h8, OP_SWAP_OPERANDS, 3'h0, 4'hE, 5'h05},
    '{8'hE4, 8'h00, 8'h00, 4'h0, OP_PORT_IN, 3'h0, 4'h0, 5'h0C},
    '{8'hE5, 8'h00, 8'h00, 4'hA, OP_PORT_IN, 3'h0, 4'h0, 5'h06},
    '{8'hE5, 8'h00, 8'h00, 4'hE, OP_PORT_IN, 3'h0, 4'h0, 5'h1A},
    '{8'hEC, 8'h00, 8'h00, 4'h0, OP_PORT_IN, 3'h0, 4'h0, 5'h0D},
    '{8'hED, 8'h00, 8'h00, 4'hA, OP_PORT_IN, 3'h0, 4'h0, 5'h07},
    '{8'hEC, 8'h00, 8'h00, 4'hC, OP_PORT_IN, 3'h0, 4'h0, 5'h1B},
    '{8'hE6, 8'h00, 8'h00, 4'h0, OP_PORT_OUT, 3'h0, 4'h0, 5'h0A},
    '{8'hE7, 8'h00, 8'h00, 4'hA, OP_PORT_OUT, 3'h0, 4'h0, 5'h04},
    '{8'hE7, 8'h00, 8'h00, 4'hE, OP_PORT_OUT, 3'h0, 4'h0, 5'h18},
    '{8'hEE, 8'h00, 8'h00, 4'h0, OP_PORT_OUT, 3'h0, 4'h0, 5'h0B},
    '{8'hEF, 8'h00, 8'h00, 4'hA, OP_PORT_OUT, 3'h0, 4'h0, 5'h05},
    '{8'hEE, 8'h00, 8'h00, 4'hC, OP_PORT_OUT, 3'h0, 4'h0, 5'h19},
    '{8'h8F, 8'hC8, 8'h00, 4'h2, OP_NONE, 3'h0, 4'h1, 5'h00}
  };

  smiod_queue_model i_queue (.clk_sys(clk_sys), .nrst(nrst), .load(load), .ld0(ld0),
    .ld1(ld1), .ld2(ld2), .instReady(instReady), .instValid(instValid),
    .opByte0(opByte0), .opByte1(opByte1), .opByte2(opByte2), .taken(taken));
  smiod_decoder i_dut (.clk_sys(clk_sys), .nrst(nrst), .instValid(instValid),
    .opByte0(opByte0), .opByte1(opByte1), .opByte2(opByte2), .protMode(protMode),
    .ioSlowPath(ioSlowPath), .instReady(instReady), .opClass(opClass), .wideOp(wideOp),
    .signExtImm(signExtImm), .segSel(segSel), .memOperand(memOperand),
    .memReadWrite(memReadWrite), .cycleCount(cycleCount), .unknownOp(unknownOp),
    .execBusy(execBusy), .execDone(execDone));

  always #12.5 clk_sys = ~clk_sys;

  task automatic conclude();
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic present(input smiod_row_t r);
    @(posedge clk_sys);
    load <= 1'h1;
    ld0 <= r.b0;
    ld1 <= r.b1;
    ld2 <= r.b2;
    protMode <= r.m[3];
    ioSlowPath <= r.m[2];
    @(posedge clk_sys);
    load <= 1'h0;
  endtask : present

  // Counts falling edges until the queue reports its bytes taken.
  task automatic wait_taken();
    for (n = 6'h01; n < 6'h3F; n++) begin
      @(negedge clk_sys);
      if (taken === 1'h1) return;
    end
    fails++;
    conclude();
  endtask : wait_taken

  task automatic check_row(input smiod_row_t r);
    logic [5:0] len;
    logic [5:0] donePos;
    if (!r.f[0]) `CHK("opClass", r.op, opClass)
    if (!r.f[0]) `CHK("cycleCount", r.cnt, cycleCount)
    `CHK("wideOp", r.m[1], wideOp)
    `CHK("signExtImm", r.m[0], signExtImm)
    if (r.op inside {OP_PUSH_SEGMENT, OP_POP_SEGMENT}) `CHK("segSel", r.seg, segSel)
    if (r.f[3]) `CHK("memOperand", r.f[2], memOperand)
    `CHK("memReadWrite", r.f[1], memReadWrite)
    `CHK("unknownOp", r.f[0], unknownOp)
    len = 6'h00;
    donePos = 6'h00;
    for (int k = 0; k < 40 && execBusy === 1'h1; k++) begin
      `CHK("instReady", 1'h0, instReady)
      len++;
      if (execDone === 1'h1) donePos = len;
      @(negedge clk_sys);
    end
    `CHK("busyLength", {1'h0, r.cnt}, len)
    `CHK("donePosition", {1'h0, r.cnt}, donePos)
    `CHK("instReady", 1'h1, instReady)
  endtask : check_row

  initial begin
    clk_sys = 1'h0;
    nrst = 1'h0;
    load = 1'h0;
    ld0 = 8'h00;
    ld1 = 8'h00;
    ld2 = 8'h00;
    protMode = 1'h0;
    ioSlowPath = 1'h0;
    fails = 0;
    checks = 0;
    @(negedge clk_sys);
    `CHK("resetReady", 1'h1, instReady)
    `CHK("resetClass", OP_NONE, opClass)
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      present(rows[i]);
      wait_taken();
      check_row(rows[i]);
    end
    // A second instruction waits while the 25-clock pop runs, then goes in at once.
    present(rows[14]);
    wait_taken();
    present(rows[17]);
    wait_taken();
    // The queued bytes stand from the second edge of the pop, so the wait spans its full count.
    `CHK("queuedWait", {1'h0, CNT_SEGPOP_PROT}, n)
    check_row(rows[17]);
    // Reset in mid-execution must drop busy and the decoded class at once.
    present(rows[13]);
    wait_taken();
    @(posedge clk_sys);
    nrst <= 1'h0;
    @(negedge clk_sys);
    `CHK("midResetBusy", 1'h0, execBusy)
    `CHK("midResetClass", OP_NONE, opClass)
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    present(rows[0]);
    wait_taken();
    check_row(rows[0]);
    conclude();
  end
endmodule : stack_move_io_opcode_decode_bench
`default_nettype wire
